// *** fspc_mem_model.sv ***
`timescale 1ns/1ps
module fspc_mem_model (
  input wire logic clk_sys_in,
  input wire logic [9:0] mem_addr_out,
  input wire logic mem_rd_out,
  output logic [15:0] mem_data_in
);
  initial mem_data_in = 16'h0000;
  // word stands only in the second phase; toggling otherwise exposes a late capture
  always @(posedge clk_sys_in) begin
    if (mem_rd_out) begin
      mem_data_in <= {6'h2a, mem_addr_out};
    end else begin
      mem_data_in <= ~mem_data_in;
    end
  end
endmodule : fspc_mem_model

// *** fspc_phase_gen.sv ***
`timescale 1ns/1ps
module fspc_phase_gen (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  fspc_phase_if.gen ph
);
  fspc_pkg::fspc_phase_t phase;
  fspc_pkg::fspc_phase_t next_phase;
  logic [3:0] onehot;
  logic [3:0] next_onehot;

  // four non-overlapping phases, one instruction cycle per lap
  always_comb begin
    case (phase)
      fspc_pkg::PH_T1: next_phase = fspc_pkg::PH_T2;
      fspc_pkg::PH_T2: next_phase = fspc_pkg::PH_T3;
      fspc_pkg::PH_T3: next_phase = fspc_pkg::PH_T4;
      fspc_pkg::PH_T4: next_phase = fspc_pkg::PH_T1;
      default: next_phase = fspc_pkg::PH_T4;
    endcase
    next_onehot = 4'h1 << next_phase;
  end

  // reset parks in the last phase so the first edge opens a fresh cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      phase <= fspc_pkg::PH_T4;
      onehot <= 4'h8;
    end else if (clk_en_in) begin
      phase <= next_phase;
      onehot <= next_onehot;
    end
  end

  assign ph.phase = phase;
  assign ph.onehot = onehot;
endmodule : fspc_phase_gen

// *** fspc_phase_if.sv ***
`timescale 1ns/1ps
interface fspc_phase_if;
  fspc_pkg::fspc_phase_t phase;
  logic [3:0] onehot;
  modport gen (output phase, output onehot);
  modport use_ph (input phase, input onehot);
endinterface : fspc_phase_if

// *** fspc_pkg.sv ***
package fspc_pkg;
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} fspc_phase_t;
  typedef enum logic {CYC_EXEC, CYC_DUMMY} fspc_cyc_t;
endpackage : fspc_pkg

// *** fspc_props.sv ***
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_props #(
  parameter int PC_W = 10
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [PC_W-1:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic exec_jump_in,
  input wire logic exec_call_in,
  input wire logic exec_ret_in,
  input wire logic exec_skip_in,
  input wire logic [PC_W-1:0] exec_target_in,
  input wire logic int_req_in,
  input wire logic int_ack_out,
  input wire logic [15:0] instr_out,
  input wire logic instr_valid_out,
  input wire logic [PC_W-1:0] exec_addr_out,
  input wire logic [3:0] phase_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_phase_rotate: assert property (
    1'b1 |=> phase_out == ($past(phase_out[3]) ? 4'h1 : 4'($past(phase_out) << 1)))
    else $error("phase order broken");
  a_fetch_t1: assert property (mem_rd_out == phase_out[0])
    else $error("fetch strobe outside first phase");
  a_addr_hold: assert property (!phase_out[0] |-> $stable(mem_addr_out))
    else $error("fetch address moved mid cycle");
  a_seq_step: assert property (
    phase_out[0] && instr_valid_out |-> mem_addr_out == exec_addr_out + 1'b1)
    else $error("counter did not advance by one");
  a_redir_dummy: assert property (
    phase_out[3] && instr_valid_out && (exec_jump_in || exec_call_in || exec_skip_in)
    |=> !instr_valid_out && instr_out == 16'h0000)
    else $error("no dummy after redirect");
  a_dummy_len: assert property ($fell(instr_valid_out) |-> !instr_valid_out [*4])
    else $error("dummy cycle length wrong");
  a_jump_tgt: assert property (
    phase_out[3] && instr_valid_out && exec_jump_in && !int_req_in && !exec_ret_in
    |=> mem_addr_out == $past(exec_target_in))
    else $error("jump target not loaded");
  a_int_vec: assert property (
    phase_out[3] && instr_valid_out && int_req_in |=> int_ack_out && mem_addr_out == `FSPC_INT_VECTOR)
    else $error("interrupt not taken");
  a_rd_idle: assert property (
    !(reg_rd_in && reg_addr_in == 8'h00) |=> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule : fspc_props
bind fspc_top fspc_props #(.PC_W(PC_W)) fspc_props_inst (.*);

// *** fspc_regs.svh ***
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH
`define FSPC_PCL_OFFSET 8'h00
`define FSPC_PCL_WIDTH 8
`define FSPC_PCL_RESET 8'h00
`define FSPC_RESET_VECTOR 10'h000
`define FSPC_INT_VECTOR 10'h004
`define FSPC_DUMMY_WORD 16'h0000
`define FSPC_READ_NONE 8'h00
`endif

// *** fspc_top.sv ***
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_top #(
  parameter int PC_W = 10,
  parameter int IW = 16,
  parameter int AW = 8,
  parameter int STACK_DEPTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [AW-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [PC_W-1:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic [IW-1:0] mem_data_in,
  input wire logic exec_jump_in,
  input wire logic exec_call_in,
  input wire logic exec_ret_in,
  input wire logic exec_skip_in,
  input wire logic [PC_W-1:0] exec_target_in,
  input wire logic int_req_in,
  output logic int_ack_out,
  output logic [IW-1:0] instr_out,
  output logic instr_valid_out,
  output logic [PC_W-1:0] exec_addr_out,
  output logic [3:0] phase_out
);
  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam int SCW = $clog2(STACK_DEPTH + 1);

  fspc_phase_if ph ();

  fspc_phase_gen u_phase (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .ph(ph)
  );

  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] next_mem_addr;
  logic next_mem_rd;
  logic [IW-1:0] fetched;
  logic [IW-1:0] next_fetched;
  logic [IW-1:0] next_instr;
  fspc_pkg::fspc_cyc_t cyc;
  fspc_pkg::fspc_cyc_t next_cyc;
  logic [PC_W-1:0] next_exec_addr;
  logic next_int_ack;
  logic pcl_pend;
  logic next_pcl_pend;
  logic [7:0] pcl_data;
  logic [7:0] next_pcl_data;
  logic [7:0] next_rdata;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp;
  logic [SPW-1:0] next_sp;
  logic [SCW-1:0] depth;
  logic [SCW-1:0] next_depth;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] target;
  logic redirect;
  logic boundary;
  logic live;
  logic stack_full;
  logic [SPW-1:0] top_idx;
  logic [7:0] pcl_view;
  // no word has been captured since reset until the first phase two passes
  logic fetch_ok;
  logic next_fetch_ok;

  assign boundary = (ph.phase == fspc_pkg::PH_T4);
  // a dummy cycle issues no work: exec and interrupt requests are only honoured on live cycles, a PCL write on any
  assign live = (cyc == fspc_pkg::CYC_EXEC);
  assign stack_full = (depth == SCW'(STACK_DEPTH));
  assign top_idx = sp - SPW'(1);
  // software sees a pending write first, else where execution stands
  assign pcl_view = pcl_pend ? pcl_data : exec_addr_out[7:0];

  // flow control, decided at the end of phase four
  always_comb begin
    target = pc;
    redirect = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_val = mem_addr_out;
    next_int_ack = 1'b0;
    if (boundary) begin
      // a full stack holds the interrupt off until a return frees a level
      if (live && int_req_in && !stack_full) begin
        target = `FSPC_INT_VECTOR;
        redirect = 1'b1;
        push = 1'b1;
        next_int_ack = 1'b1;
      end else if (live && exec_ret_in) begin
        target = stack_mem[top_idx];
        redirect = 1'b1;
        pop = 1'b1;
      end else if (live && (exec_jump_in || exec_call_in)) begin
        target = exec_target_in;
        redirect = 1'b1;
        push = exec_call_in;
      end else if (pcl_pend) begin
        target = {pc[PC_W-1:8], pcl_data};
        redirect = 1'b1;
      end else if (live && exec_skip_in) begin
        redirect = 1'b1;
      end
    end
  end

  // counter, fetch and issue
  always_comb begin
    next_pc = pc;
    next_mem_addr = mem_addr_out;
    next_mem_rd = mem_rd_out;
    next_fetched = fetched;
    next_instr = instr_out;
    next_cyc = cyc;
    next_exec_addr = exec_addr_out;
    next_fetch_ok = fetch_ok;
    case (ph.phase)
      fspc_pkg::PH_T1: begin
        next_mem_rd = 1'b0;
      end
      fspc_pkg::PH_T2: begin
        next_fetched = mem_data_in;
        next_fetch_ok = 1'b1;
      end
      fspc_pkg::PH_T3: begin
        next_fetched = fetched;
      end
      fspc_pkg::PH_T4: begin
        next_mem_addr = target;
        next_pc = target + PC_W'(1);
        next_mem_rd = 1'b1;
        next_exec_addr = mem_addr_out;
        // the word fetched last cycle executes over phases one to four
        next_instr = redirect ? `FSPC_DUMMY_WORD : fetched;
        // the lap right after reset has nothing fetched yet, so it stays a dummy
        next_cyc = (redirect || !fetch_ok) ? fspc_pkg::CYC_DUMMY : fspc_pkg::CYC_EXEC;
      end
      default: begin
        next_mem_rd = 1'b0;
      end
    endcase
  end

  // register port; a new write in the consuming cycle is kept
  always_comb begin
    next_pcl_pend = pcl_pend;
    next_pcl_data = pcl_data;
    next_rdata = `FSPC_READ_NONE;
    if (boundary && pcl_pend) begin
      next_pcl_pend = 1'b0;
    end
    if (reg_wr_in && reg_addr_in == `FSPC_PCL_OFFSET) begin
      next_pcl_pend = 1'b1;
      next_pcl_data = reg_wdata_in;
    end
    if (reg_rd_in && reg_addr_in == `FSPC_PCL_OFFSET) begin
      next_rdata = pcl_view;
    end
  end

  // stack pointer; overflow wraps and overwrites the oldest entry
  always_comb begin
    next_sp = sp;
    next_depth = depth;
    if (push) begin
      next_sp = sp + SPW'(1);
      next_depth = stack_full ? depth : depth + SCW'(1);
    end else if (pop) begin
      next_sp = top_idx;
      next_depth = (depth == SCW'(0)) ? depth : depth - SCW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
      logic [PC_W-1:0] next_entry;
      always_comb begin
        next_entry = stack_mem[gi];
        if (push && sp == SPW'(gi)) begin
          next_entry = push_val;
        end
      end
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          stack_mem[gi] <= `FSPC_RESET_VECTOR;
        end else if (clk_en_in) begin
          stack_mem[gi] <= next_entry;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pc <= `FSPC_RESET_VECTOR;
      mem_addr_out <= `FSPC_RESET_VECTOR;
      mem_rd_out <= 1'b0;
      fetched <= `FSPC_DUMMY_WORD;
      instr_out <= `FSPC_DUMMY_WORD;
      cyc <= fspc_pkg::CYC_DUMMY;
      instr_valid_out <= 1'b0;
      fetch_ok <= 1'b0;
      exec_addr_out <= `FSPC_RESET_VECTOR;
      int_ack_out <= 1'b0;
      pcl_pend <= 1'b0;
      pcl_data <= `FSPC_PCL_RESET;
      reg_rdata_out <= `FSPC_READ_NONE;
      sp <= '0;
      depth <= '0;
    end else if (clk_en_in) begin
      pc <= next_pc;
      mem_addr_out <= next_mem_addr;
      mem_rd_out <= next_mem_rd;
      fetched <= next_fetched;
      instr_out <= next_instr;
      cyc <= next_cyc;
      instr_valid_out <= (next_cyc == fspc_pkg::CYC_EXEC);
      fetch_ok <= next_fetch_ok;
      exec_addr_out <= next_exec_addr;
      int_ack_out <= next_int_ack;
      pcl_pend <= next_pcl_pend;
      pcl_data <= next_pcl_data;
      reg_rdata_out <= next_rdata;
      sp <= next_sp;
      depth <= next_depth;
    end
  end

  assign phase_out = ph.onehot;
endmodule : fspc_top

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk_sys_in, sys_rst_in, reg_wr_in, reg_rd_in, int_req_in, mem_rd_out, int_ack_out;
  logic exec_jump_in, exec_call_in, exec_ret_in, exec_skip_in, instr_valid_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [9:0] exec_target_in, mem_addr_out, exec_addr_out;
  logic [15:0] mem_data_in, instr_out;
  logic [3:0] phase_out;
  int miscompares = 0;
  int tests_run = 0;
  fspc_top fspc_top_inst (.*, .clk_en_in(1'b1));
  fspc_mem_model fspc_mem_model_inst (.*);
  function automatic logic [15:0] w(input logic [9:0] a);
    return {6'h2a, a};
  endfunction : w
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task automatic to_ph(input logic [3:0] p);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (phase_out !== p && n < 8) begin
      n++;
      @(negedge clk_sys_in);
    end
  endtask : to_ph
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    d = reg_rdata_out;
  endtask : rd
  // requests are only taken in a real cycle, so each one ends a full cycle later
  task automatic redir(input logic [4:0] k, input logic [9:0] tgt, input logic [9:0] a);
    to_ph(4'h4);
    @(posedge clk_sys_in);
    {int_req_in, exec_ret_in, exec_call_in, exec_jump_in, exec_skip_in} <= k;
    exec_target_in <= tgt;
    @(posedge clk_sys_in);
    {int_req_in, exec_ret_in, exec_call_in, exec_jump_in, exec_skip_in} <= 5'h00;
    @(negedge clk_sys_in);
    `CHK(mem_addr_out, a)
    `CHK({instr_valid_out, instr_out}, 17'h0_0000)
    `CHK(int_ack_out, k[4])
    repeat (4) @(negedge clk_sys_in);
    `CHK(instr_out, w(a))
    `CHK(exec_addr_out, a)
  endtask : redir
  task automatic t_reset();
    @(negedge clk_sys_in);
    `CHK(phase_out, 4'h1)
    `CHK(mem_addr_out, 10'h000)
    `CHK(mem_rd_out, 1'b1)
    @(negedge clk_sys_in);
    `CHK(mem_rd_out, 1'b0)
    repeat (3) @(negedge clk_sys_in);
    `CHK(instr_out, w(10'h000))
    `CHK(mem_addr_out, 10'h001)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_branch();
    redir(5'h02, 10'h123, 10'h123);
    redir(5'h04, 10'h200, 10'h200);
    redir(5'h01, 10'h000, 10'h202);
    redir(5'h08, 10'h000, 10'h124);
    redir(5'h10, 10'h000, 10'h004);
    redir(5'h08, 10'h000, 10'h125);
    $display("t_branch done");
  endtask : t_branch
  task automatic t_pcl();
    logic [7:0] d;
    wr(8'h07, 8'hff);
    rd(8'h07, d);
    `CHK(d, 8'h00)
    wr(8'h00, 8'h5a);
    rd(8'h00, d);
    `CHK(d, 8'h5a)
    `CHK({instr_valid_out, mem_addr_out}, 11'h15a)
    repeat (4) @(negedge clk_sys_in);
    `CHK(instr_out, w(10'h15a))
    rd(8'h00, d);
    `CHK(d, 8'h5a)
    $display("t_pcl done");
  endtask : t_pcl
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    miscompares++;
    test_done();
  end
  initial begin
    sys_rst_in = 1'b1;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
    {exec_jump_in, exec_call_in, exec_ret_in, exec_skip_in, int_req_in, exec_target_in} = '0;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_branch();
    t_pcl();
    test_done();
  end
endmodule : tb
